/* File: logic/cigf_pkg.sv */
// Shared constants and types of the counter input glitch filter
// What this block does
// RULE1 - Filter behaviour is set by sampling rate and required stable sample count.
// RULE2 - Input level is captured once per rising edge of the sampling clock.
// RULE3 - Sample counter counts sampling edges and clears on reaching the configured count.
// RULE4 - On that clear with no change seen, held level goes to the accumulator.
// RULE5 - Any change between samples clears the counter and restarts stability counting.
// RULE6 - Filtered level lags the raw input by at least count times sampling period.
// RULE7 - Configurer should choose sampling rate of four times count times maximum input rate.
// RULE8 - With filtering disabled the raw input passes straight through without sampling delay.
package cigf_pkg;

  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DIV_W         = 16;
  localparam int unsigned CNT_W         = 8;
  localparam int unsigned SYNC_STAGES   = 2;

  localparam logic [DIV_W-1:0] DIV_RST  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 8'h01;
  localparam logic             LVL_RST  = 1'b0;

  // Advisory ratio between sampling rate and count times input rate
  localparam int unsigned ADVISED_OVERSAMPLE = 4;

  typedef enum logic [1:0] {
    CIGF_ST_BYPASS = 2'b01,
    CIGF_ST_FILTER = 2'b10
  } cigf_state_t;

endpackage

/* File: logic/cigf_tick_if.sv */
// Sampling tick carrier between the rate divider and the filter core
`timescale 1ns/1ps
interface cigf_tick_if;
  import cigf_pkg::*;
  logic [DIV_W-1:0] div;
  logic             run;
  logic             tick;

  modport gen (input div, input run, output tick);
  modport use_side (output div, output run, input tick);
endinterface

/* File: logic/cigf_tick_gen.sv */
// Sampling clock divider: one tick every div+1 system clocks
`timescale 1ns/1ps
module cigf_tick_gen
  import cigf_pkg::*;
(
  // System
  input  wire logic clock,
  input  wire logic rst_sync_n,
  input  wire logic clk_en,
  // Tick carrier
  cigf_tick_if.gen  tk
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] cnt_nxt;
  logic             tick_r;
  logic             wrap;

  // Rate follows div at the next wrap, so a change never tears a period
  assign wrap    = (cnt_r == DIV_RST);
  assign cnt_nxt = wrap ? tk.div : cnt_r - 16'h0001;

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cnt_r  <= DIV_RST;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      cnt_r  <= tk.run ? cnt_nxt : DIV_RST; // RULE1
      tick_r <= tk.run & wrap;              // RULE1
    end
  end

  assign tk.tick = tick_r;

  a_tick_spacing: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE1
    (clk_en && tick_r && cnt_r != DIV_RST) |=> !tick_r)
    else $error("tick came closer than the divider allows");

endmodule // cigf_tick_gen

/* File: logic/cigf_filter.sv */
// Counter input glitch filter: stability filter ahead of the high speed counter
`timescale 1ns/1ps
module cigf_filter
  import cigf_pkg::*;
(
  // Clock, reset, freeze
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  // Configuration
  input  wire logic             filter_en,
  input  wire logic [DIV_W-1:0] sample_div,
  input  wire logic [CNT_W-1:0] sample_count,
  // Raw counter input from the pulse or encoder source
  input  wire logic             raw_in,
  // To the high speed counter accumulator
  output logic                  high_speed_counter_in,
  output logic                  stable_pulse,
  output logic                  filtering
);

  logic [SYNC_STAGES-1:0] rst_pipe_r;
  logic                   rst_sync_n;

  // Release of reset is synchronised; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_r <= '0;
    end else begin
      rst_pipe_r <= {rst_pipe_r[SYNC_STAGES-2:0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_r[SYNC_STAGES-1];

  cigf_tick_if tk ();

  cigf_tick_gen u_tick (
    .clock      (clock),
    .rst_sync_n (rst_sync_n),
    .clk_en     (clk_en),
    .tk         (tk.gen)
  );

  cigf_state_t      state_r;
  cigf_state_t      state_nxt;
  logic             sample_r;
  logic             sample_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             out_r;
  logic             out_nxt;
  logic             done_r;
  logic             filt_r;

  logic             in_filter;
  logic             sample_now;
  logic             changed;
  logic [CNT_W-1:0] n_eff;
  logic [CNT_W-1:0] cnt_inc;
  logic             reach;
  logic             done_now;

  assign tk.div = sample_div;
  assign tk.run = in_filter;

  // A count of zero is taken as one so the filter still forwards
  assign n_eff      = (sample_count == CNT_RST) ? CNT_ONE : sample_count;
  assign sample_now = in_filter & tk.tick;
  assign changed    = (raw_in != sample_r);
  assign cnt_inc    = cnt_r + CNT_ONE;
  assign reach      = (cnt_inc >= n_eff);
  assign done_now   = sample_now & ~changed & reach;

  assign state_nxt  = filter_en ? CIGF_ST_FILTER : CIGF_ST_BYPASS;

  // Sampled level follows the raw pin on every tick and holds between ticks; in bypass it tracks the pin every clock
  assign sample_nxt = sample_now ? raw_in : (in_filter ? sample_r : raw_in); // RULE2

  assign cnt_nxt = !sample_now ? (in_filter ? cnt_r : CNT_RST) :
                   changed     ? CNT_RST :                      // RULE5
                   reach       ? CNT_RST :                      // RULE3
                                 cnt_inc;                       // RULE3

  assign out_nxt = !in_filter ? raw_in :                        // RULE8
                   done_now   ? sample_r :                      // RULE4
                                out_r;                          // RULE6

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_r <= CIGF_ST_BYPASS;
      sample_r <= LVL_RST;
      cnt_r    <= CNT_RST;
      out_r    <= LVL_RST;
      done_r   <= 1'b0;
      filt_r   <= 1'b0;
    end else if (clk_en) begin
      state_r  <= state_nxt;
      sample_r <= sample_nxt;
      cnt_r    <= cnt_nxt;
      out_r    <= out_nxt;
      done_r   <= done_now;
      filt_r   <= filter_en;
    end
  end

  // Mode decode; an unknown code falls back to bypass so the raw level still reaches the counter
  always_comb begin
    case (state_r)
      CIGF_ST_BYPASS: in_filter = 1'b0;
      CIGF_ST_FILTER: in_filter = 1'b1;
      default:        in_filter = 1'b0;
    endcase
  end

  assign high_speed_counter_in = out_r;
  assign stable_pulse          = done_r;
  assign filtering             = filt_r;

  // Helper: count of consecutive enabled cycles the raw input has held one level
  logic [31:0] raw_hold_r;
  logic        raw_q_r;
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      raw_hold_r <= 32'h0000_0000;
      raw_q_r    <= 1'b0;
    end else if (clk_en) begin
      raw_q_r    <= raw_in;
      raw_hold_r <= (raw_in != raw_q_r) ? 32'h0000_0000 : raw_hold_r + 32'h0000_0001;
    end
  end

  // Sampling, counting and forwarding checks
  a_sample_capture: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE2
    (clk_en && sample_now) |=> (sample_r == $past(raw_in)))
    else $error("input level not captured on sampling tick");

  a_sample_hold: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE2
    (clk_en && in_filter && !tk.tick) |=> $stable(sample_r))
    else $error("sample moved without a sampling tick");

  a_count_step: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE3
    (clk_en && sample_now && !changed && !reach) |=> (cnt_r == $past(cnt_r) + CNT_ONE))
    else $error("sample counter did not advance by one");

  a_count_wrap: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE3
    (clk_en && sample_now && !changed && reach) |=> (cnt_r == CNT_RST && stable_pulse))
    else $error("sample counter did not clear at configured count");

  a_level_forward: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE4
    (clk_en && done_now) |=> (high_speed_counter_in == $past(sample_r)))
    else $error("stable level not forwarded to accumulator");

  a_change_restart: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE5
    (clk_en && sample_now && changed) |=> (cnt_r == CNT_RST && !stable_pulse))
    else $error("input change did not restart counting");

  a_out_only_done: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE6
    (clk_en && in_filter && state_nxt == CIGF_ST_FILTER && !done_now) |=> $stable(high_speed_counter_in))
    else $error("filtered level changed without a completed count");

  a_lag_bound: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE6
    (clk_en && done_now && sample_r != out_r && sample_div == DIV_RST && $stable(sample_count))
      |-> (raw_hold_r + 32'h0000_0001 >= 32'(n_eff)))
    else $error("level forwarded sooner than count times period");

  a_bypass_pass: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE8
    (clk_en && !in_filter) |=> (high_speed_counter_in == $past(raw_in)))
    else $error("bypass did not pass raw input through");

  a_mode_follow: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE1
    clk_en |=> (filtering == $past(filter_en) && in_filter == $past(filter_en)))
    else $error("filter mode did not follow enable");

  // Freeze, bypass and tick checks
  a_freeze_core: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE3
    (!clk_en) |=> ($stable(cnt_r) && $stable(sample_r)))
    else $error("counter or sample moved while frozen");

  a_freeze_outputs: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE6
    (!clk_en) |=> ($stable(high_speed_counter_in) && $stable(stable_pulse) && $stable(filtering)))
    else $error("outputs moved while frozen");

  a_count_limit: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE3
    (clk_en && sample_now && !changed) |=> (cnt_r < $past(n_eff)))
    else $error("sample counter passed the configured count");

  a_count_hold: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE3
    (clk_en && in_filter && !tk.tick) |=> $stable(cnt_r))
    else $error("sample counter moved between sampling ticks");

  a_pulse_needs_tick: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE4
    (clk_en && !sample_now) |=> !stable_pulse)
    else $error("stable pulse without a sampling tick");

  a_pulse_level: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE4
    stable_pulse |-> (high_speed_counter_in == sample_r))
    else $error("forwarded level differs from held sample");

  a_zero_count_one: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE1
    (clk_en && sample_now && !changed && sample_count == CNT_RST) |=> stable_pulse)
    else $error("count of zero did not act as one");

  a_no_tick_bypass: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE8
    (clk_en && !in_filter) |=> !tk.tick)
    else $error("sampling tick raised in bypass");

  a_bypass_sample: assert property (@(posedge clock) disable iff (!rst_sync_n) // RULE8
    (clk_en && !in_filter) |=> (sample_r == $past(raw_in) && cnt_r == CNT_RST))
    else $error("bypass did not track raw input in held sample");

  // Scenario coverage
  c_long_count: cover property (@(posedge clock) disable iff (!rst_sync_n)
    clk_en && done_now && n_eff > CNT_ONE);
  c_stable_forward: cover property (@(posedge clock) disable iff (!rst_sync_n)
    clk_en && done_now && sample_r != out_r);
  c_glitch_restart: cover property (@(posedge clock) disable iff (!rst_sync_n)
    clk_en && sample_now && changed && cnt_r != CNT_RST);
  c_bypass_toggle: cover property (@(posedge clock) disable iff (!rst_sync_n)
    clk_en && !in_filter && raw_in != out_r);
  c_mode_switch: cover property (@(posedge clock) disable iff (!rst_sync_n)
    clk_en && in_filter && !filter_en);

endmodule // cigf_filter

/* File: test/cigf_pulse_src.sv */
// Pulse or encoder source model driving the raw counter input
`timescale 1ns/1ps
module cigf_pulse_src (
  // Clock and control
  input  wire logic       clock,
  input  wire logic [7:0] half_period,
  input  wire logic       glitch,
  // Raw level to the filter
  output logic            raw_in
);
  int   cnt = 0;
  logic lvl = 1'b0;
  initial raw_in = 1'b0;
  // Zero half period stands the source still
  always @(posedge clock) begin
    #1;
    cnt++;
    if (half_period != 8'h00 && cnt >= half_period) begin
      cnt = 0;
      lvl = ~lvl;
    end
    raw_in = lvl ^ glitch;
  end
endmodule // cigf_pulse_src

/* File: test/counter_input_glitch_filter_tb.sv */
// Self-checking bench of the counter input glitch filter against a behavioural model
`timescale 1ns/1ps
module counter_input_glitch_filter_tb;
  import cigf_pkg::*;
  logic             clock = 1'b0, rst_n = 1'b0, clk_en = 1'b0, filter_en = 1'b0, glitch = 1'b0;
  logic [DIV_W-1:0] sample_div = 16'h0000;
  logic [CNT_W-1:0] sample_count = 8'h00;
  logic [7:0]       half_period = 8'h00;
  logic             raw_in, high_speed_counter_in, stable_pulse, filtering;
  logic             h, o, p, ol;
  int num_errors = 0, check_count = 0, seed = 32'hb503_350f;
  int armed = 0, f = 0, fp = 0, d = 0, c = 0, sc = 0, n = 1, t = 0;
  int cfgq[$] = '{0, 2, 1, 4, 3, 1, 0, 0, 2, 3};

  initial forever #2.5 clock = ~clock;

  cigf_filter i_cigf_filter (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .filter_en(filter_en),
    .sample_div(sample_div), .sample_count(sample_count), .raw_in(raw_in),
    .high_speed_counter_in(high_speed_counter_in), .stable_pulse(stable_pulse), .filtering(filtering));
  cigf_pulse_src i_cigf_pulse_src (.clock(clock), .half_period(half_period), .glitch(glitch), .raw_in(raw_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Model state is held while clk_en is low, as the design freezes
  always @(posedge clock) begin
    if (!rst_n) armed = 0;
    else if (armed != 0 && clk_en) begin
      n = (sample_count == 8'h00) ? 1 : int'(sample_count);
      fp = f;
      sc++;
      if (f == 0) begin
        o = raw_in;
        h = raw_in;
        d = 0;
        t = 0;
        c = 0;
        p = 1'b0;
      end else begin
        p = 1'b0;
        // The tick is registered, so a sample lands one enabled edge after the divider reaches zero
        if (t != 0) begin
          if (raw_in !== h) begin
            h = raw_in;
            c = 0;
            sc = 0;
          end else if (c + 1 >= n) begin
            o = h;
            p = 1'b1;
            c = 0;
          end else c++;
        end
        t = (d == 0) ? 1 : 0;
        d = (d == 0) ? int'(sample_div) : d - 1;
      end
      f = int'(filter_en);
    end
  end

  always @(negedge clock) begin
    if (armed != 0 && rst_n) begin
      check(high_speed_counter_in, o);
      check(stable_pulse, p);
      check(filtering, f[0]);
      if (fp != 0 && high_speed_counter_in !== ol) check(sc >= n * (int'(sample_div) + 1), 1'b1);
      ol = high_speed_counter_in;
    end
  end

  task reset_dut;
    @(posedge clock);
    #1 rst_n = 1'b0;
    clk_en = 1'b1;
    filter_en = 1'b0;
    glitch = 1'b0;
    half_period = 8'h00;
    repeat (4) @(posedge clock);
    #1 rst_n = 1'b1;
    repeat (6) @(posedge clock);
    #1 {h, o, ol, p} = {raw_in, raw_in, raw_in, 1'b0};
    f = 0;
    fp = 0;
    d = 0;
    t = 0;
    c = 0;
    sc = 0;
    armed = 1;
  endtask

  task run(input int en, input int cyc, input int hp);
    repeat (cyc) begin
      @(posedge clock);
      #1 filter_en = en[0];
      half_period = hp[7:0];
      clk_en = ($random(seed) & 7) != 0;
      glitch = ($random(seed) & 15) == 0;
    end
    $display("test done: mode %0d div %0d count %0d", en, sample_div, sample_count);
  endtask

  initial begin
    reset_dut;
    run(0, 40, 3);
    while (cfgq.size() > 1) begin
      sample_div = 16'(cfgq.pop_front());
      sample_count = 8'(cfgq.pop_front());
      // Twice the stable window per half period keeps the advised oversampling
      run(1, 300, 2 * ((sample_count == 8'h00) ? 1 : sample_count) * (sample_div + 1));
      run(0, 8, 0);
      if (cfgq.size() == 4) reset_dut;
    end
    end_of_test;
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    end_of_test;
  end
endmodule // counter_input_glitch_filter_tb
